/* shared/emp_pkg.sv */
`default_nettype none
package emp_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  // control field positions
  localparam int CTRL_RATIO_LSB = 0;
  localparam int CTRL_RSS_BIT = 2;
  localparam int CTRL_SDPRES_BIT = 3;
  localparam int CTRL_GPO_BIT = 4;
  localparam int CTRL_SREF_BIT = 5;
  localparam int CTRL_WIDTH_LSB = 6;
  localparam int CTRL_BITS = 8;
  // 64-bit memory width after reset, everything else off
  localparam logic [7:0] CTRL_RST = 8'hC0;
  // status field positions
  localparam int STAT_SRC_LSB = 0;
  localparam int STAT_HOLDA_BIT = 2;
  localparam int STAT_NEED_BIT = 3;
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_CKE_BIT = 5;
  // strobe cycles held per access
  localparam logic [2:0] ACCESS_CYCLES = 3'h2;
  // cpu clock divider terminal counts and high half lengths
  localparam logic [2:0] CPU4_LAST = 3'h3;
  localparam logic [2:0] CPU4_HIGH = 3'h2;
  localparam logic [2:0] CPU6_LAST = 3'h5;
  localparam logic [2:0] CPU6_HIGH = 3'h3;

  typedef enum logic [1:0] {
    SRC_EXT = 2'b00,
    SRC_CPU4 = 2'b01,
    SRC_CPU6 = 2'b10,
    SRC_RSVD = 2'b11
  } emp_src_e;

  typedef enum logic [1:0] {
    RATIO_1 = 2'b00,
    RATIO_2 = 2'b01,
    RATIO_4 = 2'b10
  } emp_ratio_e;

  typedef enum logic [1:0] {
    MEM_ASYNC = 2'b00,
    MEM_SDRAM = 2'b01,
    MEM_SYNC = 2'b10
  } emp_mem_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_HOLD = 2'b10
  } emp_state_e;

  // one memory access as asked for by the internal controller
  typedef struct packed {
    emp_mem_e mem_type;
    logic write;
    logic pdt;
    logic [2:0] sd_cmd; // sdram {ras, cas, we}, 1 = asserted
    logic [2:0] addr_lo;
    logic [1:0] size; // 1, 2, 4 or 8 bytes
  } emp_req_s;

  // strobe levels, 1 = asserted
  typedef struct packed {
    logic rd_shared;
    logic oe_shared;
    logic we_shared;
    logic pdt;
    logic [7:0] lanes;
  } emp_strobe_s;
endpackage : emp_pkg
`default_nettype wire

/* rtl/emp_ctrl.sv */
`default_nettype none
module emp_ctrl (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  output logic req_ready,
  input wire emp_pkg::emp_req_s req,
  input wire logic [1:0] clock_select_straps,
  input wire logic ext_input_clock,
  output logic output_clock_one,
  output logic output_clock_divided,
  output logic rd_shared_strobe_n,
  output logic rd_shared_strobe_oe,
  output logic oe_shared_strobe_n,
  output logic oe_shared_strobe_oe,
  output logic we_shared_strobe_n,
  output logic we_shared_strobe_oe,
  output logic [7:0] byte_lane_strobe_n,
  output logic byte_lane_strobe_oe,
  output logic peripheral_transfer_pin_n,
  output logic peripheral_transfer_pin_oe,
  output logic sdram_clock_gate,
  input wire logic bus_hold_request,
  output logic bus_hold_ack,
  output logic bus_need_request
);
  // lanes enabled for an access of 2^size bytes at addr_lo on a bus of
  // 2^width bytes; lanes beyond the width stay off
  function automatic logic [7:0] lane_decode(input logic [2:0] addr_lo,
                                             input logic [1:0] size,
                                             input logic [1:0] width);
    logic [7:0] span;
    logic [7:0] wmask;
    logic [2:0] lane;
    span = 8'hFF >> (4'h8 - (4'h1 << size));
    wmask = 8'hFF >> (4'h8 - (4'h1 << width));
    lane = addr_lo & ((3'h1 << width) - 3'h1); // wraps to 3'h7 on 64 bit
    lane_decode = (span << lane) & wmask;
  endfunction : lane_decode

  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic straps_taken_ff;
  emp_pkg::emp_src_e src_ff;
  logic ext_q_ff;
  logic ext_prev_ff;
  logic [2:0] cpu_cnt_ff;
  logic [2:0] nxt_cpu_cnt;
  logic clk1_ff;
  logic nxt_clk1;
  logic clk2_ff;
  logic nxt_clk2;
  logic tick_cnt_ff;
  emp_pkg::emp_state_e state_ff;
  emp_pkg::emp_state_e nxt_state;
  logic [2:0] cyc_ff;
  logic [2:0] nxt_cyc;
  emp_pkg::emp_req_s cur_ff;
  emp_pkg::emp_strobe_s stb_ff;
  emp_pkg::emp_strobe_s nxt_stb;
  logic float_ff;
  logic holda_ff;
  logic need_ff;
  logic cke_ff;
  logic nxt_cke;

  // register bus decode
  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable;
  wire hit_ctrl = paddr == emp_pkg::CTRL_OFF;
  wire hit_stat = paddr == emp_pkg::STAT_OFF;
  wire hit_any = hit_ctrl | hit_stat;
  wire ctrl_wr = access_phase & pwrite & hit_ctrl;

  wire [1:0] ratio = ctrl_ff[emp_pkg::CTRL_RATIO_LSB +: 2];
  wire rd_sel = ctrl_ff[emp_pkg::CTRL_RSS_BIT];
  wire sd_present = ctrl_ff[emp_pkg::CTRL_SDPRES_BIT];
  wire gpo_val = ctrl_ff[emp_pkg::CTRL_GPO_BIT];
  wire sref_req = ctrl_ff[emp_pkg::CTRL_SREF_BIT];
  wire [1:0] mem_width = ctrl_ff[emp_pkg::CTRL_WIDTH_LSB +: 2];

  wire [31:0] stat_word = {26'h0, cke_ff, (state_ff != emp_pkg::ST_IDLE),
                           need_ff, holda_ff, src_ff};
  wire [31:0] ctrl_word = {24'h0, ctrl_ff};

  assign pready = 1'b1;
  assign pslverr = access_phase & ~hit_any;
  assign prdata = prdata_ff;
  assign nxt_ctrl = ctrl_wr ? pwdata[emp_pkg::CTRL_BITS-1:0] : ctrl_ff;
  // read data is fetched in the setup cycle so it comes from a flop
  assign nxt_prdata = !setup_phase ? prdata_ff :
                      hit_ctrl ? ctrl_word :
                      hit_stat ? stat_word : 32'h0000_0000;

  // interface clock generation; ref_clk is the cpu clock, the external
  // clock is sampled, so it must stay well below ref_clk / 2
  wire cpu_mode = src_ff != emp_pkg::SRC_EXT;
  wire [2:0] cpu_last = (src_ff == emp_pkg::SRC_CPU6) ?
                        emp_pkg::CPU6_LAST : emp_pkg::CPU4_LAST;
  wire [2:0] cpu_high = (src_ff == emp_pkg::SRC_CPU6) ?
                        emp_pkg::CPU6_HIGH : emp_pkg::CPU4_HIGH;
  assign nxt_cpu_cnt = (cpu_cnt_ff >= cpu_last) ? 3'h0 : cpu_cnt_ff + 3'h1;
  wire cpu_level = cpu_cnt_ff < cpu_high;
  wire src_tick = cpu_mode ? (cpu_cnt_ff == 3'h0) : (ext_q_ff & ~ext_prev_ff);
  assign nxt_clk1 = cpu_mode ? cpu_level : ext_q_ff;
  // divide by 1 follows clock one, 2 and 4 toggle on source rises
  assign nxt_clk2 = (ratio == emp_pkg::RATIO_2) ? (clk2_ff ^ src_tick) :
                    (ratio == emp_pkg::RATIO_4) ?
                      (clk2_ff ^ (src_tick & tick_cnt_ff)) :
                    nxt_clk1;
  assign output_clock_one = clk1_ff;
  assign output_clock_divided = clk2_ff;

  // access and hold sequencing
  wire access_done = (state_ff == emp_pkg::ST_ACCESS) &&
                     (cyc_ff == emp_pkg::ACCESS_CYCLES - 3'h1);
  assign req_ready = (state_ff == emp_pkg::ST_IDLE) & ~bus_hold_request;

  always_comb begin
    nxt_state = state_ff;
    nxt_cyc = cyc_ff;
    case (state_ff)
      emp_pkg::ST_IDLE: begin
        nxt_cyc = 3'h0;
        if (bus_hold_request) begin
          nxt_state = emp_pkg::ST_HOLD;
        end else if (req_valid) begin
          nxt_state = emp_pkg::ST_ACCESS;
        end
      end
      emp_pkg::ST_ACCESS: begin
        nxt_cyc = cyc_ff + 3'h1;
        // a running access always completes before the bus is given up
        if (access_done) begin
          nxt_state = bus_hold_request ? emp_pkg::ST_HOLD :
                      emp_pkg::ST_IDLE;
        end
      end
      emp_pkg::ST_HOLD: begin
        // the master keeps its request up while it owns the bus
        if (!bus_hold_request) begin
          nxt_state = emp_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = emp_pkg::ST_IDLE;
      end
    endcase
  end

  // strobe levels for the next cycle, per memory type
  wire taking = (state_ff == emp_pkg::ST_IDLE) & req_valid &
                ~bus_hold_request;
  wire strobing = taking | ((state_ff == emp_pkg::ST_ACCESS) & ~access_done);
  emp_pkg::emp_req_s act;
  assign act = taking ? req : cur_ff;
  wire rd = ~act.write;

  always_comb begin
    nxt_stb = '0;
    if (strobing) begin
      case (act.mem_type)
        emp_pkg::MEM_SDRAM: begin
          nxt_stb.oe_shared = act.sd_cmd[2];
          nxt_stb.rd_shared = act.sd_cmd[1];
          nxt_stb.we_shared = act.sd_cmd[0];
        end
        emp_pkg::MEM_SYNC: begin
          // address strobe marks every access unless rd_sel makes it a read strobe, read enable only reads
          nxt_stb.rd_shared = rd_sel ? rd : 1'b1;
          nxt_stb.oe_shared = rd;
          nxt_stb.we_shared = act.write;
        end
        default: begin
          nxt_stb.rd_shared = rd;
          nxt_stb.oe_shared = rd;
          nxt_stb.we_shared = act.write;
        end
      endcase
      nxt_stb.pdt = act.pdt;
      // lanes stay active on reads too so they double as sdram masks
      nxt_stb.lanes = lane_decode(act.addr_lo, act.size,
                                  mem_width);
    end
  end

  // self refresh only with sdram fitted, otherwise a plain output
  assign nxt_cke = sd_present ? ~sref_req : gpo_val;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= emp_pkg::CTRL_RST;
      prdata_ff <= 32'h0000_0000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      prdata_ff <= nxt_prdata;
    end
  end

  // straps are caught on the first edge after reset release and kept
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      straps_taken_ff <= 1'b0;
      src_ff <= emp_pkg::SRC_EXT;
    end else if (!straps_taken_ff) begin
      straps_taken_ff <= 1'b1;
      // the reserved code falls back to the external clock
      src_ff <= (clock_select_straps == emp_pkg::SRC_RSVD) ?
                emp_pkg::SRC_EXT :
                emp_pkg::emp_src_e'(clock_select_straps);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ext_q_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
      cpu_cnt_ff <= 3'h0;
      clk1_ff <= 1'b0;
      clk2_ff <= 1'b0;
      tick_cnt_ff <= 1'b0;
    end else begin
      ext_q_ff <= ext_input_clock;
      ext_prev_ff <= ext_q_ff;
      cpu_cnt_ff <= nxt_cpu_cnt;
      clk1_ff <= nxt_clk1;
      clk2_ff <= nxt_clk2;
      tick_cnt_ff <= tick_cnt_ff ^ src_tick;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= emp_pkg::ST_IDLE;
      cyc_ff <= 3'h0;
      cur_ff <= '0;
      stb_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cyc_ff <= nxt_cyc;
      cur_ff <= act;
      stb_ff <= nxt_stb;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      float_ff <= 1'b0;
      holda_ff <= 1'b0;
      need_ff <= 1'b0;
      cke_ff <= 1'b1;
    end else begin
      float_ff <= nxt_state == emp_pkg::ST_HOLD;
      holda_ff <= nxt_state == emp_pkg::ST_HOLD;
      need_ff <= req_valid & (nxt_state == emp_pkg::ST_HOLD);
      cke_ff <= nxt_cke;
    end
  end

  assign rd_shared_strobe_n = ~stb_ff.rd_shared;
  assign oe_shared_strobe_n = ~stb_ff.oe_shared;
  assign we_shared_strobe_n = ~stb_ff.we_shared;
  assign byte_lane_strobe_n = ~stb_ff.lanes;
  assign peripheral_transfer_pin_n = ~stb_ff.pdt;
  assign rd_shared_strobe_oe = ~float_ff;
  assign oe_shared_strobe_oe = ~float_ff;
  assign we_shared_strobe_oe = ~float_ff;
  assign byte_lane_strobe_oe = ~float_ff;
  assign peripheral_transfer_pin_oe = ~float_ff;
  assign sdram_clock_gate = cke_ff;
  assign bus_hold_ack = holda_ff;
  assign bus_need_request = need_ff;
endmodule : emp_ctrl
`default_nettype wire

/* bench/emp_far_model.sv */
`default_nettype none
module emp_far_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic want_bus,
  output logic bus_hold_request,
  output var logic ext_input_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  // board oscillator, 8 ref periods, free running and off the rising ref edges
  initial ext_input_clock = 1'b0;
  always #160 ext_input_clock = ~ext_input_clock;
  // request stays up for as long as the master uses the bus
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) bus_hold_request <= 1'b0;
    else bus_hold_request <= want_bus;
  end
endmodule : emp_far_model
`default_nettype wire

/* bench/emp_ctrl_chk.sv */
`default_nettype none
module emp_ctrl_chk (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire emp_pkg::emp_req_s req,
  input wire logic bus_hold_request,
  input wire logic bus_hold_ack,
  input wire logic bus_need_request,
  input wire logic rd_shared_strobe_n,
  input wire logic rd_shared_strobe_oe,
  input wire logic oe_shared_strobe_n,
  input wire logic oe_shared_strobe_oe,
  input wire logic we_shared_strobe_n,
  input wire logic we_shared_strobe_oe,
  input wire logic [7:0] byte_lane_strobe_n,
  input wire logic peripheral_transfer_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  wire logic take = req_valid && req_ready;
  wire logic as_op = req.mem_type == emp_pkg::MEM_ASYNC;
  a_float_hold: assert property (
    bus_hold_ack |-> !rd_shared_strobe_oe && !oe_shared_strobe_oe
    && !we_shared_strobe_oe) else $error("strobes driven in hold");
  a_ack_cause: assert property (
    $rose(bus_hold_ack) |-> $past(bus_hold_request))
    else $error("ack without request");
  a_ack_release: assert property (
    !bus_hold_request |=> !bus_hold_ack) else $error("ack kept");
  a_write_len: assert property (
    take && as_op && req.write |=> !we_shared_strobe_n [*2]
    ##1 we_shared_strobe_n) else $error("write strobe length");
  a_read_pins: assert property (
    take && as_op && !req.write |=> !rd_shared_strobe_n
    && !oe_shared_strobe_n) else $error("read strobes missing");
  a_pdt_pin: assert property (
    take && req.pdt |=> !peripheral_transfer_pin_n)
    else $error("transfer pin missing");
  a_lanes_idle: assert property (
    req_ready |-> byte_lane_strobe_n == 8'hFF) else $error("lanes busy");
  a_need_cause: assert property (
    $rose(bus_need_request) |-> $past(req_valid))
    else $error("need without request");
endmodule : emp_ctrl_chk
bind emp_ctrl emp_ctrl_chk emp_ctrl_chk_inst (.ref_clk, .rstn, .req_valid,
  .req_ready, .req, .bus_hold_request, .bus_hold_ack, .bus_need_request,
  .rd_shared_strobe_n, .rd_shared_strobe_oe, .oe_shared_strobe_n,
  .oe_shared_strobe_oe, .we_shared_strobe_n, .we_shared_strobe_oe,
  .byte_lane_strobe_n, .peripheral_transfer_pin_n);
`default_nettype wire

/* bench/emp_ctrl_tb.sv */
`default_nettype none
module emp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, req_ready, want, ck1, ck2, ext, hreq;
  logic req_valid = 1'b0;
  logic [1:0] straps = 2'h0;
  emp_pkg::emp_req_s req = '0;
  logic rd_n, rd_oe, oe_n, oe_oe, we_n, we_oe, pdt_n, ack, need, cke;
  logic ln_oe, pdt_oe;
  logic [7:0] ln_n;
  wire logic [11:0] pins = {rd_n, oe_n, we_n, pdt_n, ln_n};
  int n_errors = 0;
  int n_checks = 0;
  initial want = 1'b0;
  always #20 ref_clk = ~ref_clk;
  emp_far_model emp_far_model_inst (.ref_clk, .rstn, .want_bus(want),
    .bus_hold_request(hreq), .ext_input_clock(ext));
  emp_ctrl emp_ctrl_inst (.ref_clk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .req_valid, .req_ready,
    .req, .clock_select_straps(straps), .ext_input_clock(ext),
    .output_clock_one(ck1), .output_clock_divided(ck2),
    .rd_shared_strobe_n(rd_n), .rd_shared_strobe_oe(rd_oe),
    .oe_shared_strobe_n(oe_n), .oe_shared_strobe_oe(oe_oe),
    .we_shared_strobe_n(we_n), .we_shared_strobe_oe(we_oe),
    .byte_lane_strobe_n(ln_n), .byte_lane_strobe_oe(ln_oe),
    .peripheral_transfer_pin_n(pdt_n), .peripheral_transfer_pin_oe(pdt_oe),
    .sdram_clock_gate(cke), .bus_hold_request(hreq), .bus_hold_ack(ack),
    .bus_need_request(need));
  task automatic results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic guard(int i);
    if (i >= 40) begin
      n_errors++;
      results();
    end
  endtask : guard
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i == 0 || (pready !== 1'b1 && i < 40); i++)
      @(posedge ref_clk);
    guard(i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic acc(emp_pkg::emp_req_s r, logic [11:0] exp);
    int i;
    @(posedge ref_clk);
    req <= r;
    req_valid <= 1'b1;
    for (i = 0; i == 0 || (req_ready !== 1'b1 && i < 40); i++)
      @(posedge ref_clk);
    guard(i);
    req_valid <= 1'b0;
    @(negedge ref_clk);
    chk("strobes", pins, exp);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("idle", pins, 12'hFFF);
  endtask : acc
  // ck2 when s, else ck1; counts ref edges until the level is reached
  task automatic lvl(logic s, logic v, inout int p);
    int i;
    for (i = 0; i < 40 && (s ? ck2 : ck1) !== v; i++) begin
      @(posedge ref_clk);
      p++;
    end
    guard(i);
  endtask : lvl
  task automatic per(logic s, logic [31:0] exp);
    int p;
    p = 0;
    lvl(s, 1'b0, p);
    lvl(s, 1'b1, p);
    p = 0;
    lvl(s, 1'b0, p);
    lvl(s, 1'b1, p);
    chk("clock period", p, exp);
  endtask : per
  task automatic t_regs;
    apb(1'b0, emp_pkg::CTRL_OFF, 32'h0);
    chk("ctrl reset", rd, 32'hC0);
    apb(1'b1, 8'h08, 32'hFFFFFFFF);
    chk("unmapped err", err, 32'h1);
    apb(1'b0, emp_pkg::CTRL_OFF, 32'h0);
    chk("ctrl kept", rd, 32'hC0);
  endtask : t_regs
  task automatic t_access;
    acc(12'h00D, 12'h3E7);
    acc(12'h303, 12'hC00);
    acc(12'h4D2, 12'h30F);
    acc(12'h620, 12'hDFE);
    acc(12'h804, 12'h3FD);
    acc(12'hA04, 12'h5FD);
    apb(1'b1, emp_pkg::CTRL_OFF, 32'h44);
    acc(12'hA0C, 12'hDFD);
    acc(12'h809, 12'h3FC);
    apb(1'b1, emp_pkg::CTRL_OFF, 32'h80);
    acc(12'h019, 12'h3F3);
    apb(1'b1, emp_pkg::CTRL_OFF, 32'h00);
    acc(12'h214, 12'hDFE);
  endtask : t_access
  task automatic t_hold;
    int i;
    @(posedge ref_clk);
    want <= 1'b1;
    for (i = 0; i < 40 && ack !== 1'b1; i++) @(posedge ref_clk);
    guard(i);
    req <= 12'h00D;
    req_valid <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("oe in hold", {rd_oe, oe_oe, we_oe}, 32'h0);
    chk("lane oe in hold", {ln_oe, pdt_oe}, 32'h0);
    chk("ready in hold", req_ready, 32'h0);
    chk("need", need, 32'h1);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    want <= 1'b0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("release", {ack, rd_oe, need}, 32'h2);
    chk("lane oe back", {ln_oe, pdt_oe}, 32'h3);
  endtask : t_hold
  task automatic t_cke;
    logic [31:0] t [4] = '{32'hC8, 32'hE8, 32'hD0, 32'hC0};
    logic [3:0] e = 4'h5;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, emp_pkg::CTRL_OFF, t[k]);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk("clock gate", cke, e[k]);
    end
  endtask : t_cke
  task automatic t_clocks;
    logic [31:0] p1 [4] = '{32'h8, 32'h4, 32'h6, 32'h8};
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk);
      straps <= 2'(s);
      rstn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      apb(1'b0, emp_pkg::STAT_OFF, 32'h0);
      chk("source", rd[1:0], s == 3 ? 32'h0 : 32'(s));
      per(1'b0, p1[s]);
    end
    for (int r = 0; r < 3; r++) begin
      apb(1'b1, emp_pkg::CTRL_OFF, 32'hC0 | 32'(r));
      per(1'b1, 32'h8 << r);
    end
  endtask : t_clocks
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs;
    t_access;
    t_hold;
    t_cke;
    t_clocks;
    results;
  end
endmodule : emp_ctrl_tb
`default_nettype wire
